/* File: verilog/smlo_pkg.sv */
// Package for the special-move, multiply and logic decode/execute block
package smlo_pkg;

    // Data and register-number widths
    localparam int DATA_W = 32;
    localparam int REG_W  = 4;
    localparam int SEL_W  = 8;

    // 16-bit opcode patterns (upper bits, compared under the masks below)
    localparam logic [15:0] OPC_PRODUCT   = 16'h4340;   // 0100_0011_01xx_xxxx
    localparam logic [15:0] OPC_INVERT    = 16'h43c0;   // 0100_0011_11xx_xxxx
    localparam logic [15:0] OPC_OR        = 16'h4300;   // 0100_0011_00xx_xxxx
    localparam logic [15:0] OPC_REVSUB    = 16'h4240;   // 0100_0010_01xx_xxxx
    localparam logic [15:0] MASK_ALU16    = 16'hffc0;
    localparam logic [15:0] OPC_NOP       = 16'hbf00;
    // 32-bit first halfwords
    localparam logic [15:0] OPC_S2G_HI    = 16'hf3ef;
    localparam logic [15:0] OPC_G2S_HI    = 16'hf380;
    localparam logic [15:0] MASK_G2S_HI   = 16'hfff0;
    // 32-bit second halfword checks
    localparam logic [15:0] OPC_S2G_LO    = 16'h8000;
    localparam logic [15:0] MASK_S2G_LO   = 16'hf000;
    localparam logic [15:0] OPC_G2S_LO    = 16'h8800;
    localparam logic [15:0] MASK_G2S_LO   = 16'hff00;

    // Field positions in a halfword
    localparam int F_LO_REG  = 0;   // low 3-bit register field
    localparam int F_MID_REG = 3;   // second 3-bit register field
    localparam int F_HI_RD   = 8;   // destination field in second halfword

    // Special register selects that application level may read; of these it may write only the status word
    localparam logic [SEL_W-1:0] SEL_APP_STATUS = 8'h00;
    localparam logic [SEL_W-1:0] SEL_MODE_CTRL  = 8'h14;

    // Condition flags of the status word
    typedef struct packed {
        logic neg;
        logic zero;
        logic carry;
        logic ovf;
    } smlo_flags_t;

    localparam smlo_flags_t FLAGS_RESET = '{neg: 1'b0, zero: 1'b0, carry: 1'b0, ovf: 1'b0};

    // Instruction handed in by fetch
    typedef struct packed {
        logic        valid;
        logic        wide;       // two-halfword form
        logic [15:0] hw1;
        logic [15:0] hw2;
        logic        cond_pass;
        logic        in_cond_blk;
        logic        privileged;
    } smlo_instr_t;

    // Write-back command to the register file and special registers
    typedef struct packed {
        logic              gpr_we;
        logic [REG_W-1:0]  gpr_addr;
        logic [DATA_W-1:0] gpr_data;
        logic              spec_we;
        logic [SEL_W-1:0]  spec_sel;
        logic [DATA_W-1:0] spec_data;
        logic              priv_fault;
        logic              done;
    } smlo_wb_t;

    localparam smlo_wb_t WB_RESET = '0;

endpackage

/* File: verilog/smlo_exec.sv */
// Decode and execute of special moves, multiply, invert, negate, no-op and OR
`timescale 1ns/1ps
`default_nettype none

module smlo_exec
    import smlo_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Instruction from fetch
    input  wire smlo_instr_t       instr,
    // Register file read ports (addresses are combinational from instr)
    output logic [REG_W-1:0]       rd_addr_a,
    output logic [REG_W-1:0]       rd_addr_b,
    input  wire logic [DATA_W-1:0] rd_data_a,
    input  wire logic [DATA_W-1:0] rd_data_b,
    // Special register read port
    output logic [SEL_W-1:0]       spec_rd_sel,
    input  wire logic [DATA_W-1:0] spec_rd_data,
    // Write-back and status word
    output smlo_wb_t               wb,
    output smlo_flags_t            flags
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Negative and zero flags from a result
    function automatic logic [1:0] nz_of(input logic [DATA_W-1:0] v);
        return {v[DATA_W-1], (v == '0)};
    endfunction

    // Three-bit register field widened to a register number
    function automatic logic [REG_W-1:0] lo_reg(input logic [2:0] f);
        return {1'b0, f};
    endfunction

    // Short-form ALU opcode match under the common mask
    function automatic logic alu16_is(input logic [15:0] hw, input logic [15:0] opc);
        return (hw & MASK_ALU16) == opc;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decode

    logic is_prod;
    logic is_inv;
    logic is_or;
    logic is_rsb;
    logic is_nop;
    logic is_s2g;
    logic is_g2s;
    logic [SEL_W-1:0] sel;

    // Opcode match on the incoming halfwords
    // At most one decode flag is high for a legal halfword pair; the short
    // forms are gated off by the wide bit, so a second halfword can never
    // alias one of them.
    always_comb begin
        is_prod = !instr.wide && alu16_is(instr.hw1, OPC_PRODUCT);
        is_inv  = !instr.wide && alu16_is(instr.hw1, OPC_INVERT);
        is_or   = !instr.wide && alu16_is(instr.hw1, OPC_OR);
        is_rsb  = !instr.wide && alu16_is(instr.hw1, OPC_REVSUB);
        is_nop  = !instr.wide && (instr.hw1 == OPC_NOP);
        is_s2g  = instr.wide && (instr.hw1 == OPC_S2G_HI)
                  && ((instr.hw2 & MASK_S2G_LO) == OPC_S2G_LO);
        is_g2s  = instr.wide && ((instr.hw1 & MASK_G2S_HI) == OPC_G2S_HI)
                  && ((instr.hw2 & MASK_G2S_LO) == OPC_G2S_LO);
        sel     = instr.hw2[SEL_W-1:0];
    end

    // Operand addresses to the register file
    // They come straight from the halfword so the register file answers in
    // the same cycle. The short multiply reads its destination field as the
    // second operand; the short OR reads it as the first operand, which
    // keeps the OR operands in their documented order.
    always_comb begin
        rd_addr_a   = lo_reg(instr.hw1[F_MID_REG +: 3]);
        rd_addr_b   = lo_reg(instr.hw1[F_LO_REG +: 3]);
        spec_rd_sel = sel;
        if (is_g2s) begin
            rd_addr_a = instr.hw1[F_LO_REG +: REG_W];
        end
        if (is_or) begin
            rd_addr_a = lo_reg(instr.hw1[F_LO_REG +: 3]);
            rd_addr_b = lo_reg(instr.hw1[F_MID_REG +: 3]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Execute

    // The write-back command is a one-cycle pulse per taken instruction.
    // The flags are a level that only a flag-setting instruction or a
    // status word write moves; a failed condition leaves both registers
    // and flags where they are.
    smlo_wb_t    wb_reg;
    smlo_wb_t    wb_next;
    smlo_flags_t flags_reg;
    smlo_flags_t flags_next;

    logic [DATA_W-1:0]   res;
    logic [2*DATA_W-1:0] prod;
    logic [DATA_W:0]     diff;
    logic                setf;
    logic                app_ok;

    // Result select and flag update
    always_comb begin
        wb_next    = WB_RESET;
        flags_next = flags_reg;
        res        = '0;
        prod       = '0;
        diff       = '0;
        app_ok     = 1'b0;
        setf       = !instr.in_cond_blk;
        if (instr.valid && instr.cond_pass) begin
            wb_next.done     = 1'b1;
            wb_next.gpr_addr = lo_reg(instr.hw1[F_LO_REG +: 3]);
            if (is_prod) begin
                // Unsigned product; its low word equals the signed one
                prod             = rd_data_a * rd_data_b;
                res              = prod[DATA_W-1:0];
                wb_next.gpr_we   = 1'b1;
                wb_next.gpr_data = res;
                if (setf) begin
                    {flags_next.neg, flags_next.zero} = nz_of(res);
                end
            end else if (is_inv) begin
                res              = ~(rd_data_a << 0);
                wb_next.gpr_we   = 1'b1;
                wb_next.gpr_data = res;
                if (setf) begin
                    {flags_next.neg, flags_next.zero} = nz_of(res);
                end
            end else if (is_or) begin
                res              = rd_data_a | rd_data_b;
                wb_next.gpr_we   = 1'b1;
                wb_next.gpr_data = res;
                if (setf) begin
                    {flags_next.neg, flags_next.zero} = nz_of(res);
                end
            end else if (is_rsb) begin
                // Zero minus source; borrow clear sets carry
                diff             = {1'b0, {DATA_W{1'b0}}} - {1'b0, rd_data_a};
                res              = diff[DATA_W-1:0];
                wb_next.gpr_we   = 1'b1;
                wb_next.gpr_data = res;
                if (setf) begin
                    {flags_next.neg, flags_next.zero} = nz_of(res);
                    flags_next.carry = ~diff[DATA_W];
                    flags_next.ovf   = rd_data_a[DATA_W-1] & res[DATA_W-1];
                end
            end else if (is_s2g) begin
                // Unprivileged access outside the application registers raises
                // a fault pulse instead of any write, so the core can trap it
                app_ok = (sel == SEL_APP_STATUS) || (sel == SEL_MODE_CTRL);
                if (instr.privileged || app_ok) begin
                    wb_next.gpr_we   = 1'b1;
                    wb_next.gpr_addr = instr.hw2[F_HI_RD +: REG_W];
                    // Status word read packs N, Z, C, V into the top four bits
                    wb_next.gpr_data = (sel == SEL_APP_STATUS)
                                       ? {flags_reg, {(DATA_W-4){1'b0}}}
                                       : spec_rd_data;
                end else begin
                    wb_next.priv_fault = 1'b1;
                end
            end else if (is_g2s) begin
                app_ok = (sel == SEL_APP_STATUS);
                if (app_ok) begin
                    flags_next = smlo_flags_t'(rd_data_a[DATA_W-1 -: 4]);
                end else if (instr.privileged) begin
                    wb_next.spec_we   = 1'b1;
                    wb_next.spec_sel  = sel;
                    wb_next.spec_data = rd_data_a;
                end else begin
                    wb_next.priv_fault = 1'b1;
                end
            end else if (is_nop) begin
                // Hint only: no register, flag or special write
                wb_next.gpr_we = 1'b0;
            end
            // No-op and unknown opcodes leave state alone
        end
    end

    // State registers
    // Reset clears the pending write-back and all four flags
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_reg    <= WB_RESET;
            flags_reg <= FLAGS_RESET;
        end else begin
            wb_reg    <= wb_next;
            flags_reg <= flags_next;
        end
    end

    // Outputs straight from flip-flops
    assign wb    = wb_reg;
    assign flags = flags_reg;

endmodule

`default_nettype wire

/* File: dv/smlo_monitor.sv */
// Checker of write-back and flag behaviour at the block ports
`timescale 1ns/1ps
`default_nettype none
module smlo_monitor
    import smlo_pkg::*;
(
    // Clock, reset and watched ports
    input wire logic              clk,
    input wire logic              arst_n,
    input wire smlo_instr_t       instr,
    input wire logic [DATA_W-1:0] rd_data_a,
    input wire logic [DATA_W-1:0] rd_data_b,
    input wire smlo_wb_t          wb,
    input wire smlo_flags_t       flags
);
    // Decoded takes and operand views
    wire logic              go    = instr.valid && instr.cond_pass;
    wire logic              s16   = go && !instr.wide;
    wire logic              prd   = s16 && (instr.hw1 & MASK_ALU16) == OPC_PRODUCT;
    wire logic              inv   = s16 && (instr.hw1 & MASK_ALU16) == OPC_INVERT;
    wire logic              ior   = s16 && (instr.hw1 & MASK_ALU16) == OPC_OR;
    wire logic              rsb   = s16 && (instr.hw1 & MASK_ALU16) == OPC_REVSUB;
    wire logic              g2s   = go && instr.wide && (instr.hw1 & MASK_G2S_HI) == OPC_G2S_HI;
    wire logic [DATA_W-1:0] neg_v = '0 - rd_data_a;
    wire logic [DATA_W-1:0] prod  = rd_data_a * rd_data_b;
    wire logic [DATA_W-1:0] ior_v = rd_data_a | rd_data_b;
    wire logic [REG_W-1:0]  lo_rg = {1'b0, instr.hw1[2:0]};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Flag steps shared by the logic operations
    sequence s_kept;
        flags.carry == $past(flags.carry) && flags.ovf == $past(flags.ovf);
    endsequence
    sequence s_nz;
        flags.neg == wb.gpr_data[31] && flags.zero == (wb.gpr_data == '0);
    endsequence
    a_fail_quiet: assert property (instr.valid && !instr.cond_pass |=>
        !wb.done && !wb.gpr_we && !wb.spec_we && $stable(flags)) else $error("failed op wrote");
    a_nop_quiet: assert property (s16 && instr.hw1 == OPC_NOP |=>
        !wb.gpr_we && !wb.spec_we && $stable(flags)) else $error("no-op changed state");
    a_prd_low: assert property (prd |=> wb.gpr_we && wb.gpr_data == $past(prod))
        else $error("product value wrong");
    a_prd_dest: assert property (prd |=> wb.gpr_addr == $past(lo_rg))
        else $error("product destination wrong");
    a_prd_flags: assert property (prd && !instr.in_cond_blk |=> s_nz and s_kept)
        else $error("product flags wrong");
    a_inv_flags: assert property (inv && !instr.in_cond_blk |=> s_nz and s_kept)
        else $error("invert flags wrong");
    a_ior_value: assert property (ior |=> wb.gpr_data == $past(ior_v)
        && wb.gpr_addr == $past(lo_rg)) else $error("or result wrong");
    a_ior_flags: assert property (ior && !instr.in_cond_blk |=> s_nz and s_kept)
        else $error("or flags wrong");
    a_blk_hold: assert property ((prd || inv || ior) && instr.in_cond_blk |=>
        $stable(flags)) else $error("flags set inside block");
    a_g2s_guard: assert property (g2s && !instr.privileged
        && instr.hw2[7:0] != SEL_APP_STATUS |=> wb.priv_fault && !wb.spec_we)
        else $error("unprivileged write passed");
    a_neg_value: assert property (rsb |=> wb.gpr_we && wb.gpr_data == $past(neg_v))
        else $error("negate value wrong");
    a_inv_value: assert property (inv |=> wb.gpr_we && wb.gpr_data == ~$past(rd_data_a))
        else $error("invert value wrong");
endmodule
bind smlo_exec smlo_monitor u_smlo_monitor (.clk(clk), .arst_n(arst_n), .instr(instr),
    .rd_data_a(rd_data_a), .rd_data_b(rd_data_b), .wb(wb), .flags(flags));
`default_nettype wire

/* File: dv/smlo_regs_model.sv */
// Register file and special register model behind the read ports
`timescale 1ns/1ps
`default_nettype none
module smlo_regs_model
    import smlo_pkg::*;
(
    // Read selects from the block
    input  wire logic [REG_W-1:0] rd_addr_a,
    input  wire logic [REG_W-1:0] rd_addr_b,
    input  wire logic [SEL_W-1:0] spec_rd_sel,
    // Read data back, same cycle
    output logic [DATA_W-1:0]     rd_data_a,
    output logic [DATA_W-1:0]     rd_data_b,
    output logic [DATA_W-1:0]     spec_rd_data
);
    // Values built from the register number, so a wrong select shows
    assign rd_data_a    = {rd_addr_a, 24'h000000, rd_addr_a};
    assign rd_data_b    = {rd_addr_b, 24'h000000, rd_addr_b};
    assign spec_rd_data = {24'ha5a5a5, spec_rd_sel};
endmodule
`default_nettype wire

/* File: dv/test_smlo_exec.sv */
// Self-checking bench for the special-move, multiply and logic block
`timescale 1ns/1ps
`default_nettype none
module test_smlo_exec
    import smlo_pkg::*;
;
    logic clk, arst_n;
    smlo_instr_t instr;
    smlo_wb_t wb;
    smlo_flags_t flags;
    logic [REG_W-1:0] rd_addr_a, rd_addr_b;
    logic [SEL_W-1:0] spec_rd_sel;
    logic [DATA_W-1:0] rd_data_a, rd_data_b, spec_rd_data;
    int n_mismatch = 0;
    int checks_done = 0;
    smlo_exec u_smlo_exec (.clk(clk), .arst_n(arst_n), .instr(instr), .rd_addr_a(rd_addr_a),
        .rd_addr_b(rd_addr_b), .rd_data_a(rd_data_a), .rd_data_b(rd_data_b),
        .spec_rd_sel(spec_rd_sel), .spec_rd_data(spec_rd_data), .wb(wb), .flags(flags));
    smlo_regs_model u_smlo_regs_model (.rd_addr_a(rd_addr_a), .rd_addr_b(rd_addr_b),
        .spec_rd_sel(spec_rd_sel), .rd_data_a(rd_data_a), .rd_data_b(rd_data_b),
        .spec_rd_data(spec_rd_data));
    // Clock source
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [DATA_W-1:0] rv(input logic [3:0] i);
        return {i, 24'h000000, i};
    endfunction
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One instruction for one cycle, then settle on its write-back
    task automatic issue(input logic w, input logic [15:0] h1, input logic [15:0] h2,
                         input logic ok, input logic blk, input logic pr);
        @(posedge clk);
        instr <= '{valid: 1'b1, wide: w, hw1: h1, hw2: h2, cond_pass: ok,
                   in_cond_blk: blk, privileged: pr};
        @(posedge clk);
        instr.valid <= 1'b0;
        #1;
    endtask
    task automatic cw(input logic [3:0] a, input logic [DATA_W-1:0] d, input logic [3:0] f);
        chk({wb.gpr_we, wb.priv_fault, wb.done, wb.spec_we, 24'h0, wb.gpr_addr},
            {2'b10, 2'b10, 24'h0, a});
        chk(wb.gpr_data, d);
        chk({28'h0, flags}, {28'h0, f});
    endtask
    task automatic t_negate();
        issue(1'b0, 16'h4253, 16'h0, 1'b1, 1'b0, 1'b0);
        cw(4'h3, -rv(4'h2), 4'b1000);
        issue(1'b0, 16'h4241, 16'h0, 1'b1, 1'b0, 1'b0);
        cw(4'h1, 32'h0, 4'b0110);
    endtask
    task automatic t_product();
        logic [DATA_W-1:0] p;
        p = rv(4'h3) * rv(4'h5);
        issue(1'b0, 16'h435d, 16'h0, 1'b1, 1'b0, 1'b0);
        cw(4'h5, p, {p[31], 3'b010});
        issue(1'b0, 16'h4345, 16'h0, 1'b1, 1'b0, 1'b0);
        cw(4'h5, 32'h0, 4'b0110);
        issue(1'b0, 16'h435d, 16'h0, 1'b0, 1'b0, 1'b0);
        chk({wb.done, wb.gpr_we, 26'h0, flags}, {28'h0, 4'b0110});
    endtask
    task automatic t_invert_or();
        issue(1'b0, 16'h43d6, 16'h0, 1'b1, 1'b0, 1'b0);
        cw(4'h6, ~rv(4'h2), 4'b1010);
        issue(1'b0, 16'h430c, 16'h0, 1'b1, 1'b0, 1'b0);
        cw(4'h4, rv(4'h4) | rv(4'h1), 4'b0010);
        issue(1'b0, 16'h4308, 16'h0, 1'b1, 1'b1, 1'b0);
        cw(4'h0, rv(4'h1), 4'b0010);
        issue(1'b0, OPC_NOP, 16'h0, 1'b1, 1'b0, 1'b0);
        chk({wb.gpr_we, wb.spec_we, 26'h0, flags}, {28'h0, 4'b0010});
    endtask
    task automatic t_special();
        issue(1'b1, OPC_S2G_HI, 16'h8714, 1'b1, 1'b0, 1'b0);
        cw(4'h7, {24'ha5a5a5, 8'h14}, 4'b0010);
        issue(1'b1, OPC_S2G_HI, 16'h8200, 1'b1, 1'b0, 1'b0);
        cw(4'h2, 32'h20000000, 4'b0010);
        issue(1'b1, OPC_S2G_HI, 16'h8208, 1'b1, 1'b0, 1'b0);
        chk({30'h0, wb.priv_fault, wb.gpr_we}, 32'h2);
        issue(1'b1, 16'hf385, 16'h8808, 1'b1, 1'b0, 1'b1);
        chk({23'h0, wb.spec_we, wb.spec_sel}, {23'h0, 1'b1, 8'h08});
        chk(wb.spec_data, rv(4'h5));
        issue(1'b1, 16'hf385, 16'h8808, 1'b1, 1'b0, 1'b0);
        chk({30'h0, wb.priv_fault, wb.spec_we}, 32'h2);
        issue(1'b1, 16'hf389, 16'h8800, 1'b1, 1'b0, 1'b0);
        chk({27'h0, wb.priv_fault, flags}, {27'h0, 5'b01001});
    endtask
    // Mid-run reset clears the flags, then an OR runs from clean flags
    task automatic t_reset();
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk({27'h0, (wb !== WB_RESET), flags}, 32'h0);
        issue(1'b0, 16'h4308, 16'h0, 1'b1, 1'b0, 1'b0);
        cw(4'h0, rv(4'h1), 4'b0000);
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        instr = '0;
        arst_n = 1'b0;
        repeat (8) @(posedge clk);
        chk({27'h0, (wb !== WB_RESET), flags}, 32'h0);
        arst_n <= 1'b1;
        t_negate();
        t_product();
        t_invert_or();
        t_special();
        t_reset();
        report_and_stop();
    end
    // Watchdog against a hang
    initial begin
        #20000;
        n_mismatch++;
        report_and_stop();
    end
endmodule
`default_nettype wire
